// ---- dv/cpu_side_model.sv ----
// CPU-side partner: issues sleep and interrupt requests and times the settling wait.
// Assumes the bench raises each request for exactly one clock.
`timescale 1ns/1ps
module cpu_side_model (
  input  wire logic        i_clk,        // System clock
  input  wire logic        i_reset,      // Async reset, active high
  input  wire logic        i_go_sleep,   // Bench asks for a sleep instruction
  input  wire logic        i_go_ext,     // Bench asks for an external interrupt
  input  wire logic        i_go_wake,    // Bench asks for a sleep-ending interrupt
  input  wire logic        i_cpu_halt,   // CPU halt from the controller
  input  wire logic        i_exc_start,  // Exception start pulse
  output logic             o_sleep_exec, // Sleep instruction pulse
  output logic             o_ext_irq,    // External interrupt
  output logic             o_wake_irq,   // Interrupt accepted in sleep
  output logic [19:0]      o_wait_cnt    // Edges from interrupt to exception start
);
  logic timing_ff;
  // A halted CPU cannot execute another sleep instruction
  assign o_sleep_exec = i_go_sleep & ~i_cpu_halt;
  assign o_ext_irq    = i_go_ext;
  assign o_wake_irq   = i_go_wake;
  // Times the held span so the bench can judge the settling length
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      timing_ff  <= 1'b0;
      o_wait_cnt <= '0;
    end else if (o_ext_irq) begin
      timing_ff  <= 1'b1;
      o_wait_cnt <= '0;
    end else if (timing_ff) begin
      o_wait_cnt <= o_wait_cnt + 20'h1;
      if (i_exc_start) begin
        timing_ff <= 1'b0;
      end
    end
  end
endmodule : cpu_side_model

// ---- dv/power_down_module_standby_ctrl_test.sv ----
// Testbench: register access, module standby map, sleep, software and hardware standby.
// Assumes shortened settling waits for codes 1 to 5; codes 0 and 6 keep their full length.
`timescale 1ns/1ps
module power_down_module_standby_ctrl_test;
  import pwr_down_pkg::*;
  logic I_REF_CLK = 1'b0, I_RESET = 1'b1, I_WR = 1'b0, I_RD = 1'b0, I_HW_STANDBY = 1'b0;
  logic [19:0] I_ADDR = '0;
  logic [7:0] I_WDATA = '0, O_RDATA;
  logic go_sleep = 1'b0, go_ext = 1'b0, go_wake = 1'b0, sleep_exec, ext_irq, wake_irq;
  logic O_CPU_HALT, O_OSC_STOP, O_CHIP_CLK_HOLD, O_IRQ_EXC_START, O_REFRESH_INIT;
  logic O_BUS_FLOAT, O_BUS_HOLD, O_CLK_OUT_EN, O_RAM_ENABLE;
  logic [19:0] wait_cnt;
  module_gate_t O_MODULE_STOP, O_MODULE_INIT;
  int n_errors = 0, cmp_count = 0;
  // External clock assumed, so every legal code is usable
  int wt[8] = '{8192, 16, 32, 64, 128, 256, 1024, 256};
  always #50 I_REF_CLK = ~I_REF_CLK;
  power_down_module_standby_ctrl #(.WAIT_CODE1(16), .WAIT_CODE2(32), .WAIT_CODE3(64),
    .WAIT_CODE4(128), .WAIT_CODE5(256)) u_power_down_module_standby_ctrl (
    .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SLEEP_EXEC(sleep_exec), .I_WAKE_IRQ(wake_irq),
    .I_EXT_IRQ(ext_irq), .I_HW_STANDBY(I_HW_STANDBY), .O_CPU_HALT(O_CPU_HALT), .O_OSC_STOP(O_OSC_STOP),
    .O_CHIP_CLK_HOLD(O_CHIP_CLK_HOLD), .O_IRQ_EXC_START(O_IRQ_EXC_START),
    .O_REFRESH_INIT(O_REFRESH_INIT), .O_BUS_FLOAT(O_BUS_FLOAT), .O_BUS_HOLD(O_BUS_HOLD),
    .O_CLK_OUT_EN(O_CLK_OUT_EN), .O_RAM_ENABLE(O_RAM_ENABLE), .O_MODULE_STOP(O_MODULE_STOP),
    .O_MODULE_INIT(O_MODULE_INIT));
  cpu_side_model u_cpu_side_model (.i_clk(I_REF_CLK), .i_reset(I_RESET), .i_go_sleep(go_sleep),
    .i_go_ext(go_ext), .i_go_wake(go_wake), .i_cpu_halt(O_CPU_HALT), .i_exc_start(O_IRQ_EXC_START),
    .o_sleep_exec(sleep_exec), .o_ext_irq(ext_irq), .o_wake_irq(wake_irq), .o_wait_cnt(wait_cnt));

  task automatic chk_out(input string name, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_out

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge I_REF_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_REF_CLK);
    I_WR <= 1'b0;
  endtask : wr

  task automatic chk_reg(input logic [19:0] a, input logic [7:0] exp);
    @(posedge I_REF_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_REF_CLK);
    I_RD <= 1'b0;
    #1 chk_out("register", 20'(exp), 20'(O_RDATA));
  endtask : chk_reg

  // Expected peripheral gates from the two standby registers
  function automatic module_gate_t gate(input logic [7:0] hi, input logic [7:0] lo);
    gate = {hi[0], hi[1], hi[2], lo[7], lo[5], lo[4], lo[3], lo[2], lo[0]};
  endfunction : gate

  // One-cycle request: 0 sleep instruction, 1 external interrupt, 2 sleep-ending interrupt
  task automatic pulse(input int sel);
    @(posedge I_REF_CLK);
    if (sel == 0) begin
      go_sleep <= 1'b1;
    end else if (sel == 1) begin
      go_ext <= 1'b1;
    end else begin
      go_wake <= 1'b1;
    end
    @(posedge I_REF_CLK);
    go_sleep <= 1'b0;
    go_ext   <= 1'b0;
    go_wake  <= 1'b0;
  endtask : pulse

  task automatic do_sleep(input logic sw);
    pulse(0);
    #1 chk_out("refresh_init", 20'(sw), 20'(O_REFRESH_INIT));
    @(posedge I_REF_CLK);
    #1 chk_out("refresh_init", 20'h0, 20'(O_REFRESH_INIT));
    repeat (3) @(posedge I_REF_CLK);
    #1 chk_out("cpu_halt", 20'h1, 20'(O_CPU_HALT));
    chk_out("clk_hold", 20'(sw), 20'(O_CHIP_CLK_HOLD));
  endtask : do_sleep

  task automatic wait_run();
    for (int k = 0; k < 9000 && O_CPU_HALT !== 1'b0; k++) @(posedge I_REF_CLK);
    repeat (2) @(posedge I_REF_CLK);
    #1 chk_out("cpu_halt", 20'h0, 20'(O_CPU_HALT));
  endtask : wait_run

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [7:0] v;
    repeat (8) @(posedge I_REF_CLK);
    I_RESET <= 1'b0;
    chk_reg(ADDR_SYSTEM_CONTROL, 8'h09);
    chk_reg(ADDR_MODULE_STBY_HI, 8'h78);
    chk_reg(ADDR_MODULE_STBY_LO, 8'h00);
    chk_out("clk_out_en", 20'h1, 20'(O_CLK_OUT_EN));
    wr(ADDR_MODULE_STBY_HI, 8'h00);
    chk_reg(ADDR_MODULE_STBY_HI, 8'h78);
    wr(ADDR_MODULE_STBY_HI, 8'h87);
    chk_reg(ADDR_MODULE_STBY_HI, 8'hff);
    chk_out("clk_out_en", 20'h0, 20'(O_CLK_OUT_EN));
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_MODULE_STBY_LO, 8'h01 << i);
      chk_reg(ADDR_MODULE_STBY_LO, 8'h01 << i);
      chk_out("module_stop", 20'(gate(8'h87, 8'h01 << i)), 20'(O_MODULE_STOP));
      chk_out("module_init", 20'(gate(8'h87, 8'h01 << i)), 20'(O_MODULE_INIT));
    end
    wr(20'hee013, 8'hff);
    wr(20'h6e01d, 8'hff);
    chk_reg(20'hee013, 8'h00);
    chk_reg(20'h6e01d, 8'h00);
    chk_reg(ADDR_MODULE_STBY_LO, 8'h80);
    wr(ADDR_MODULE_STBY_LO, 8'h42);
    do_sleep(1'b0);
    chk_out("module_stop", 20'(gate(8'h87, 8'h42)), 20'(O_MODULE_STOP));
    chk_out("osc_stop", 20'h0, 20'(O_OSC_STOP));
    pulse(2);
    wait_run();
    for (int c = 0; c < 8; c++) begin
      v = 8'h89 | 8'(c << 4) | ((c % 2 == 1) ? 8'h02 : 8'h00);
      wr(ADDR_SYSTEM_CONTROL, v);
      chk_reg(ADDR_SYSTEM_CONTROL, v);
      do_sleep(1'b1);
      chk_out("osc_stop", 20'h1, 20'(O_OSC_STOP));
      chk_out("bus_hold", 20'(c[0]), 20'(O_BUS_HOLD));
      chk_out("bus_float", 20'(!c[0]), 20'(O_BUS_FLOAT));
      chk_out("module_stop", 20'h1ff, 20'(O_MODULE_STOP));
      chk_out("module_init", 20'h1ef, 20'(O_MODULE_INIT));
      pulse(1);
      wait_run();
      chk_out("settle_wait", 20'(wt[c] + 1), wait_cnt);
      chk_reg(ADDR_SYSTEM_CONTROL, v);
      chk_reg(ADDR_MODULE_STBY_HI, 8'hff);
      chk_reg(ADDR_MODULE_STBY_LO, 8'h42);
    end
    wr(ADDR_SYSTEM_CONTROL, 8'h01);
    @(posedge I_REF_CLK);
    #1 chk_out("ram_enable", 20'h0, 20'(O_RAM_ENABLE));
    @(posedge I_REF_CLK);
    I_HW_STANDBY <= 1'b1;
    repeat (4) @(posedge I_REF_CLK);
    #1 chk_out("bus_float", 20'h1, 20'(O_BUS_FLOAT));
    @(posedge I_REF_CLK);
    I_HW_STANDBY <= 1'b0;
    repeat (3) @(posedge I_REF_CLK);
    chk_reg(ADDR_MODULE_STBY_HI, 8'h78);
    chk_reg(ADDR_MODULE_STBY_LO, 8'h00);
    chk_reg(ADDR_SYSTEM_CONTROL, 8'h09);
    chk_out("clk_out_en", 20'h1, 20'(O_CLK_OUT_EN));
    end_of_test();
  end
endmodule : power_down_module_standby_ctrl_test

// ---- hw/power_down_module_standby_ctrl.sv ----
// Power-down controller: sleep / software standby / hardware standby sequencing,
// settling wait, bus pin state in standby, clock output gate and module standby.
// Assumes a single 10 MHz clock (one state per clock) and a CPU register port
// with read data returned one cycle after the read strobe.
//
// Operation
// - Module standby bit at 1 resets that peripheral; software clears it, then reprograms.
// - Standby select bit 7: 0 sleep instruction enters sleep, 1 software standby.
// - Standby select stays 1 after interrupt exit; only a write of 0 or hardware standby clears it.
// - Settle field bits 6..4 picks 8192..262144 or 1024 states; 111 illegal.
// - Settling wait only on interrupt exit; CPU and peripherals held meanwhile.
// - Output keep bit 1: 0 bus floats in standby, 1 holds address, strobes high.
// - High module standby loads 0x78 on reset and hardware standby, kept otherwise.
// - Low module standby loads 0x00 on reset and hardware standby, kept otherwise.
// - High register bit 7 at 1 disables the system clock output.
// - High register bits 6..3 ignore writes and read as 1.
// - High register bits 2..0 put serial channels 2..0 in standby.
// - Low register bit 7 puts the DMA controller in standby.
// - Low register bit 5 halts DRAM interface, bit 4 the 16-bit timer.
// - Low register bit 3 halts 8-bit timer channels 0/1, bit 2 channels 2/3.
// - Low register bit 0 puts the A/D converter in standby.
// - Low register bits 6 and 1 are plain read/write storage.
// - Software standby entry initialises refresh counter and refresh status bits 7..6.
// - Decode matches the 20-bit register addresses.
// - Sleep halts the CPU only; DMA, DRAM and running peripherals continue.
// - Interrupt in software standby restarts oscillator, waits, then starts exception.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module power_down_module_standby_ctrl
  import pwr_down_pkg::*;
#(
  parameter int unsigned WAIT_CODE0 = 8192,    // Settling states, code 000
  parameter int unsigned WAIT_CODE1 = 16384,   // Settling states, code 001
  parameter int unsigned WAIT_CODE2 = 32768,   // Settling states, code 010
  parameter int unsigned WAIT_CODE3 = 65536,   // Settling states, code 011
  parameter int unsigned WAIT_CODE4 = 131072,  // Settling states, code 100
  parameter int unsigned WAIT_CODE5 = 262144,  // Settling states, code 101
  parameter int unsigned WAIT_CODE6 = 1024     // Settling states, code 110
) (
  input  wire logic         I_REF_CLK,         // System clock, 10 MHz
  input  wire logic         I_RESET,           // Asynchronous reset, active high
  input  wire logic [19:0]  I_ADDR,            // Register address, lower 20 bits
  input  wire logic [7:0]   I_WDATA,           // Register write data
  input  wire logic         I_WR,              // Write strobe
  input  wire logic         I_RD,              // Read strobe
  output logic      [7:0]   O_RDATA,           // Read data, cycle after strobe
  input  wire logic         I_SLEEP_EXEC,      // Sleep instruction executed, pulse
  input  wire logic         I_WAKE_IRQ,        // Accepted interrupt, ends sleep
  input  wire logic         I_EXT_IRQ,         // External interrupt, ends software standby
  input  wire logic         I_HW_STANDBY,      // Standby pin asserted, level
  output logic              O_CPU_HALT,        // CPU halted, registers kept
  output logic              O_OSC_STOP,        // Oscillator stopped
  output logic              O_CHIP_CLK_HOLD,   // Clocks withheld from CPU and peripherals
  output logic              O_IRQ_EXC_START,   // Start interrupt exception handling, pulse
  output logic              O_REFRESH_INIT,    // Initialise refresh counter and status, pulse
  output logic              O_BUS_FLOAT,       // Address bus and strobes high impedance
  output logic              O_BUS_HOLD,        // Address held, strobes driven high
  output logic              O_CLK_OUT_EN,      // System clock output pin enabled
  output logic              O_RAM_ENABLE,      // On-chip RAM enable
  output module_gate_t      O_MODULE_STOP,     // Per-module clock halt
  output module_gate_t      O_MODULE_INIT      // Per-module register initialise
);

  pwr_state_t                state_ff;
  pwr_state_t                nxt_state;
  logic [7:0]                sysctl_ff;
  logic [7:0]                mst_hi_ff;
  logic [7:0]                mst_lo_ff;
  logic [SETTLE_CNT_W-1:0]   settle_cnt_ff;
  logic [7:0]                nxt_rdata;
  logic                      wr_sysctl;
  logic                      wr_mst_hi;
  logic                      wr_mst_lo;
  logic                      enter_sw_stby;
  logic                      settle_done;
  logic                      stby_select;
  logic                      output_keep;
  module_gate_t              gate_bits;

  // Settling wait length for a code; the illegal code takes the code 101 wait
  function automatic logic [SETTLE_CNT_W-1:0] settle_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: settle_cycles = SETTLE_CNT_W'(WAIT_CODE0);
      3'h1: settle_cycles = SETTLE_CNT_W'(WAIT_CODE1);
      3'h2: settle_cycles = SETTLE_CNT_W'(WAIT_CODE2);
      3'h3: settle_cycles = SETTLE_CNT_W'(WAIT_CODE3);
      3'h4: settle_cycles = SETTLE_CNT_W'(WAIT_CODE4);
      3'h5: settle_cycles = SETTLE_CNT_W'(WAIT_CODE5);
      3'h6: settle_cycles = SETTLE_CNT_W'(WAIT_CODE6);
      default: settle_cycles = SETTLE_CNT_W'(WAIT_CODE5);
    endcase
  endfunction : settle_cycles

  // Address match on the full 20-bit value
  function automatic logic addr_hit(input logic [19:0] addr, input logic [19:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction : addr_hit

  assign wr_sysctl = I_WR && addr_hit(I_ADDR, ADDR_SYSTEM_CONTROL);
  assign wr_mst_hi = I_WR && addr_hit(I_ADDR, ADDR_MODULE_STBY_HI);
  assign wr_mst_lo = I_WR && addr_hit(I_ADDR, ADDR_MODULE_STBY_LO);

  assign stby_select = sysctl_ff[SC_STANDBY_SELECT];
  assign output_keep = sysctl_ff[SC_OUTPUT_KEEP];
  assign enter_sw_stby = (state_ff == ST_RUN) && I_SLEEP_EXEC && stby_select && !I_HW_STANDBY;
  assign settle_done = (state_ff == ST_SETTLE) && (settle_cnt_ff == SETTLE_CNT_W'(1));

  // Register file; hardware standby reloads initial values
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sysctl_ff <= RST_SYSTEM_CONTROL;
    end else if (I_HW_STANDBY) begin
      sysctl_ff <= RST_SYSTEM_CONTROL;
    end else if (wr_sysctl) begin
      sysctl_ff <= I_WDATA;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      mst_hi_ff <= RST_MODULE_STBY_HI;
    end else if (I_HW_STANDBY) begin
      mst_hi_ff <= RST_MODULE_STBY_HI;
    end else if (wr_mst_hi) begin
      mst_hi_ff <= (I_WDATA & HI_STORED_MASK) | HI_FIXED_ONES;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      mst_lo_ff <= RST_MODULE_STBY_LO;
    end else if (I_HW_STANDBY) begin
      mst_lo_ff <= RST_MODULE_STBY_LO;
    end else if (wr_mst_lo) begin
      mst_lo_ff <= I_WDATA;
    end
  end

  // Read data, unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (addr_hit(I_ADDR, ADDR_SYSTEM_CONTROL)) begin
      nxt_rdata = sysctl_ff;
    end else if (addr_hit(I_ADDR, ADDR_MODULE_STBY_HI)) begin
      nxt_rdata = mst_hi_ff | HI_FIXED_ONES;
    end else if (addr_hit(I_ADDR, ADDR_MODULE_STBY_LO)) begin
      nxt_rdata = mst_lo_ff;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= nxt_rdata;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // Power state sequencing
  always_comb begin
    nxt_state = state_ff;
    if (I_HW_STANDBY) begin
      nxt_state = ST_HW_STBY;
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          if (I_SLEEP_EXEC) begin
            nxt_state = stby_select ? ST_SW_STBY : ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (I_WAKE_IRQ) begin
            nxt_state = ST_RUN;
          end
        end
        ST_SW_STBY: begin
          if (I_EXT_IRQ) begin
            nxt_state = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_done) begin
            nxt_state = ST_RUN;
          end
        end
        ST_HW_STBY: begin
          nxt_state = ST_RUN;
        end
        default: begin
          nxt_state = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settling counter, loaded as the oscillator restarts
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      settle_cnt_ff <= '0;
    end else if (state_ff == ST_SW_STBY && I_EXT_IRQ && !I_HW_STANDBY) begin
      settle_cnt_ff <= settle_cycles(sysctl_ff[SC_SETTLE_MSB:SC_SETTLE_LSB]);
    end else if (state_ff == ST_SETTLE && settle_cnt_ff != '0) begin
      settle_cnt_ff <= settle_cnt_ff - SETTLE_CNT_W'(1);
    end
  end

  // Module standby bit map
  always_comb begin
    gate_bits             = '0;
    gate_bits.serial0     = mst_hi_ff[HI_SERIAL0];
    gate_bits.serial1     = mst_hi_ff[HI_SERIAL1];
    gate_bits.serial2     = mst_hi_ff[HI_SERIAL2];
    gate_bits.dma         = mst_lo_ff[LO_DMA];
    gate_bits.dram_if     = mst_lo_ff[LO_DRAM_IF];
    gate_bits.timer16     = mst_lo_ff[LO_TIMER16];
    gate_bits.timer8_ch01 = mst_lo_ff[LO_TIMER8_CH01];
    gate_bits.timer8_ch23 = mst_lo_ff[LO_TIMER8_CH23];
    gate_bits.adc         = mst_lo_ff[LO_ADC];
  end

  // Chip-level outputs, one cycle behind the state
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CPU_HALT      <= 1'b0;
      O_OSC_STOP      <= 1'b0;
      O_CHIP_CLK_HOLD <= 1'b0;
    end else begin
      O_CPU_HALT      <= (state_ff != ST_RUN);
      O_OSC_STOP      <= (state_ff == ST_SW_STBY) || (state_ff == ST_HW_STBY);
      O_CHIP_CLK_HOLD <= (state_ff == ST_SW_STBY) || (state_ff == ST_SETTLE)
                         || (state_ff == ST_HW_STBY);
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_IRQ_EXC_START <= 1'b0;
      O_REFRESH_INIT  <= 1'b0;
    end else begin
      O_IRQ_EXC_START <= (settle_done && !I_HW_STANDBY)
                         || (state_ff == ST_SLEEP && I_WAKE_IRQ && !I_HW_STANDBY);
      O_REFRESH_INIT  <= enter_sw_stby;
    end
  end

  // Bus pins in standby
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_BUS_FLOAT <= 1'b0;
      O_BUS_HOLD  <= 1'b0;
    end else begin
      O_BUS_FLOAT <= (state_ff == ST_HW_STBY)
                     || ((state_ff == ST_SW_STBY || state_ff == ST_SETTLE) && !output_keep);
      O_BUS_HOLD  <= (state_ff == ST_SW_STBY || state_ff == ST_SETTLE) && output_keep;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CLK_OUT_EN <= 1'b1;
      O_RAM_ENABLE <= 1'b1;
    end else begin
      O_CLK_OUT_EN <= !mst_hi_ff[HI_CLOCK_OUT_STOP];
      O_RAM_ENABLE <= sysctl_ff[SC_RAM_ENABLE];
    end
  end

  // Module gating: standby bit halts and resets; software standby halts and resets
  // all but the DRAM interface, which is only held
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_MODULE_STOP <= '0;
      O_MODULE_INIT <= '0;
    end else begin
      O_MODULE_STOP <= gate_bits | {$bits(module_gate_t){state_ff != ST_RUN && state_ff != ST_SLEEP}};
      O_MODULE_INIT <= gate_bits
                       | ({$bits(module_gate_t){state_ff != ST_RUN && state_ff != ST_SLEEP}}
                          & ~module_gate_t'({4'h0, 1'b1, 4'h0}));
    end
  end

  // Helper: cycles spent in the settling state
  logic [SETTLE_CNT_W-1:0] settle_len_ff;
  logic [SETTLE_CNT_W-1:0] settle_want_ff;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      settle_len_ff  <= '0;
      settle_want_ff <= '0;
    end else if (state_ff == ST_SW_STBY) begin
      settle_len_ff  <= '0;
      settle_want_ff <= settle_cycles(sysctl_ff[SC_SETTLE_MSB:SC_SETTLE_LSB]);
    end else if (state_ff == ST_SETTLE) begin
      settle_len_ff  <= settle_len_ff + SETTLE_CNT_W'(1);
    end
  end

  sequence s_sleep_req;
    state_ff == ST_RUN && I_SLEEP_EXEC && !I_HW_STANDBY;
  endsequence

  sequence s_settle_end;
    state_ff == ST_SETTLE && !I_HW_STANDBY ##1 state_ff == ST_RUN;
  endsequence

  a_sw_stby_entry: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    s_sleep_req and stby_select |=> state_ff == ST_SW_STBY ##1 O_CPU_HALT && O_OSC_STOP)
    else $error("sleep with standby select did not reach software standby");

  a_sleep_entry: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    s_sleep_req and !stby_select |=> state_ff == ST_SLEEP ##1 O_CPU_HALT && !O_OSC_STOP
    && O_MODULE_STOP == $past(gate_bits))
    else $error("sleep mode entry wrong");

  a_select_sticky: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    $fell(stby_select) |-> $past(wr_sysctl && !I_WDATA[SC_STANDBY_SELECT]) || $past(I_HW_STANDBY))
    else $error("standby select cleared without a write");

  a_settle_length: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    s_settle_end |-> settle_len_ff == settle_want_ff)
    else $error("settling wait has wrong length");

  a_settle_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    state_ff == ST_SETTLE && !settle_done |=> O_CHIP_CLK_HOLD && O_CPU_HALT && !O_IRQ_EXC_START)
    else $error("clocks released during settling wait");

  a_exit_exception: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    s_settle_end |-> O_IRQ_EXC_START ##1 !O_CHIP_CLK_HOLD && !O_IRQ_EXC_START)
    else $error("no exception start after settling");

  a_bus_pins: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    state_ff == ST_SW_STBY |=> (O_BUS_HOLD == $past(output_keep)) && (O_BUS_FLOAT == !$past(output_keep)))
    else $error("bus pin state in standby wrong");

  a_hi_reserved: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    I_RD && addr_hit(I_ADDR, ADDR_MODULE_STBY_HI) |=> O_RDATA[6:3] == 4'hf)
    else $error("reserved high bits not read as one");

  a_hw_reload: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    I_HW_STANDBY |=> mst_hi_ff == RST_MODULE_STBY_HI && mst_lo_ff == RST_MODULE_STBY_LO)
    else $error("module standby registers not reloaded");

  a_clock_out: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    wr_mst_hi && !I_HW_STANDBY |=> ##1 O_CLK_OUT_EN == !$past(I_WDATA[HI_CLOCK_OUT_STOP], 2))
    else $error("clock output gate does not follow bit 7");

  a_refresh_init: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    s_sleep_req and stby_select |=> O_REFRESH_INIT ##1 !O_REFRESH_INIT)
    else $error("refresh initialise pulse missing");

  a_module_init: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    state_ff == ST_RUN && !I_HW_STANDBY |=> O_MODULE_INIT == $past(gate_bits))
    else $error("module initialise does not follow standby bits");

endmodule : power_down_module_standby_ctrl

// ---- hw/pwr_down_pkg.sv ----
// Power-down control package: register map, field positions, reset values,
// settling waits and the power state encoding.
// Assumes a 20-bit register address and an 8-bit register data path.
package pwr_down_pkg;

  // Register addresses, lower 20 bits of the full address
  localparam logic [19:0] ADDR_SYSTEM_CONTROL = 20'hee012;
  localparam logic [19:0] ADDR_MODULE_STBY_HI = 20'hee01c;
  localparam logic [19:0] ADDR_MODULE_STBY_LO = 20'hee01d;

  // Reset values
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h09;
  localparam logic [7:0] RST_MODULE_STBY_HI = 8'h78;
  localparam logic [7:0] RST_MODULE_STBY_LO = 8'h00;

  // Fixed ones in the high module standby register
  localparam logic [7:0] HI_FIXED_ONES = 8'h78;
  localparam logic [7:0] HI_STORED_MASK = 8'h87;

  // system_control fields
  localparam int SC_STANDBY_SELECT = 7;
  localparam int SC_SETTLE_MSB = 6;
  localparam int SC_SETTLE_LSB = 4;
  localparam int SC_RAM_ENABLE = 3;
  localparam int SC_OUTPUT_KEEP = 1;

  // module_standby_high fields
  localparam int HI_CLOCK_OUT_STOP = 7;
  localparam int HI_SERIAL2 = 2;
  localparam int HI_SERIAL1 = 1;
  localparam int HI_SERIAL0 = 0;

  // module_standby_low fields
  localparam int LO_DMA = 7;
  localparam int LO_DRAM_IF = 5;
  localparam int LO_TIMER16 = 4;
  localparam int LO_TIMER8_CH01 = 3;
  localparam int LO_TIMER8_CH23 = 2;
  localparam int LO_ADC = 0;

  // Settling wait codes
  localparam logic [2:0] SETTLE_CODE_ILLEGAL = 3'h7;
  localparam int SETTLE_CNT_W = 19;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_SLEEP    = 3'b001,
    ST_SW_STBY  = 3'b010,
    ST_SETTLE   = 3'b011,
    ST_HW_STBY  = 3'b100
  } pwr_state_t;

  // One bit per gated peripheral
  typedef struct packed {
    logic serial0;
    logic serial1;
    logic serial2;
    logic dma;
    logic dram_if;
    logic timer16;
    logic timer8_ch01;
    logic timer8_ch23;
    logic adc;
  } module_gate_t;

endpackage : pwr_down_pkg
